// ===== logic/rtcc_calendar.sv
// bcd time counters with carry chain and parallel load
`timescale 1ns/1ns
`default_nettype none
module rtcc_calendar (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic tick,
	input wire logic load,
	input wire rtcc_pkg::rtcc_time_s load_val,
	output rtcc_pkg::rtcc_time_s cnt_ff
);
	rtcc_pkg::rtcc_time_s nxt_cnt;
	logic [8:0] s_inc, m_inc, h_inc, w_inc, d_inc, mo_inc, y_inc;

	always_comb begin
		nxt_cnt = cnt_ff;
		s_inc = rtcc_pkg::bcd_inc(cnt_ff.seconds, rtcc_pkg::MAX_SEC,
			rtcc_pkg::MIN_ZERO);
		m_inc = rtcc_pkg::bcd_inc(cnt_ff.minutes, rtcc_pkg::MAX_MIN,
			rtcc_pkg::MIN_ZERO);
		h_inc = rtcc_pkg::bcd_inc(cnt_ff.hours, rtcc_pkg::MAX_HOUR,
			rtcc_pkg::MIN_ZERO);
		w_inc = rtcc_pkg::bcd_inc(cnt_ff.wday, rtcc_pkg::MAX_WDAY,
			rtcc_pkg::MIN_ONE);
		d_inc = rtcc_pkg::bcd_inc(cnt_ff.mday,
			rtcc_pkg::month_len(cnt_ff.month, cnt_ff.year), rtcc_pkg::MIN_ONE);
		mo_inc = rtcc_pkg::bcd_inc(cnt_ff.month, rtcc_pkg::MAX_MONTH,
			rtcc_pkg::MIN_ONE);
		y_inc = rtcc_pkg::bcd_inc(cnt_ff.year, rtcc_pkg::MAX_YEAR,
			rtcc_pkg::MIN_ZERO);
		if (load) begin
			nxt_cnt = load_val;
		end else if (tick) begin
			nxt_cnt.seconds = s_inc[7:0];
			if (s_inc[8]) begin
				nxt_cnt.minutes = m_inc[7:0];
				if (m_inc[8]) begin
					nxt_cnt.hours = h_inc[7:0];
					if (h_inc[8]) begin
						nxt_cnt.wday = w_inc[7:0];
						nxt_cnt.mday = d_inc[7:0];
						if (d_inc[8]) begin
							nxt_cnt.month = mo_inc[7:0];
							if (mo_inc[8])
								nxt_cnt.year = y_inc[7:0];
						end
					end
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst)
			cnt_ff <= rtcc_pkg::RST_TIME;
		else if (ce)
			cnt_ff <= nxt_cnt;
	end
endmodule : rtcc_calendar
`default_nettype wire

// ===== logic/rtcc_divider.sv
// oscillator divider with periodic calibration, one pulse per second
`timescale 1ns/1ns
`default_nettype none
module rtcc_divider #(
	parameter int OSC_CYC = rtcc_pkg::OSC_CYC
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic hold,
	input wire logic restart,
	input wire logic cal_sign,
	input wire logic [4:0] cal_mag,
	output logic sec_tick_ff,
	output logic test_wave_ff
);
	logic [15:0] mcnt_ff, nxt_mcnt;
	logic [15:0] osc_ff, nxt_osc;
	logic [5:0] sec_ff, nxt_sec;
	logic [5:0] cyc_ff, nxt_cyc;
	logic nxt_tick;
	logic [15:0] period;
	logic corr;

	always_comb begin
		nxt_mcnt = mcnt_ff;
		nxt_osc = osc_ff;
		nxt_sec = sec_ff;
		nxt_cyc = cyc_ff;
		nxt_tick = 1'b0;
		// first second of an eligible minute, 2n minutes out of the first 62
		corr = (sec_ff == 6'h00) && ({1'b0, cyc_ff} < {1'b0, cal_mag, 1'b0})
			&& ({1'b0, cyc_ff} < rtcc_pkg::CAL_ELIG_MIN);
		// sign 1 splits half a /256 count, sign 0 blanks a whole one
		if (!corr)
			period = rtcc_pkg::SEC_OSC;
		else if (cal_sign)
			period = rtcc_pkg::SEC_OSC - rtcc_pkg::CAL_SHORT;
		else
			period = rtcc_pkg::SEC_OSC + rtcc_pkg::CAL_LONG;
		if (restart) begin
			// a fresh start times the first second from zero; sec_ff and cyc_ff keep their counts, so it can be corrected
			nxt_mcnt = 16'h0000;
			nxt_osc = 16'h0000;
		end else if (!hold) begin
			if (mcnt_ff >= 16'(OSC_CYC - 1)) begin
				nxt_mcnt = 16'h0000;
				if (osc_ff >= period - 16'h0001) begin
					nxt_osc = 16'h0000;
					nxt_tick = 1'b1;
					nxt_sec = (sec_ff >= rtcc_pkg::SEC_LAST) ? 6'h00 :
						sec_ff + 6'h01;
					if (sec_ff >= rtcc_pkg::SEC_LAST)
						nxt_cyc = (cyc_ff >= rtcc_pkg::CAL_CYCLE_LAST) ? 6'h00 :
							cyc_ff + 6'h01;
				end else begin
					nxt_osc = osc_ff + 16'h0001;
				end
			end else begin
				nxt_mcnt = mcnt_ff + 16'h0001;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mcnt_ff <= 16'h0000;
			osc_ff <= 16'h0000;
			sec_ff <= 6'h00;
			cyc_ff <= 6'h00;
			sec_tick_ff <= 1'b0;
			test_wave_ff <= 1'b0;
		end else if (ce) begin
			mcnt_ff <= nxt_mcnt;
			osc_ff <= nxt_osc;
			sec_ff <= nxt_sec;
			cyc_ff <= nxt_cyc;
			sec_tick_ff <= nxt_tick;
			test_wave_ff <= osc_ff[rtcc_pkg::TEST_WAVE_BIT];
		end
	end
endmodule : rtcc_divider
`default_nettype wire

// ===== logic/rtcc_pkg.sv
// package: register map, field layout, reset values and helpers of the clock
package rtcc_pkg;

	localparam logic [18:0] ADDR_CTRL = 19'h7FFF8;
	localparam logic [18:0] ADDR_SEC = 19'h7FFF9;
	localparam logic [18:0] ADDR_MIN = 19'h7FFFA;
	localparam logic [18:0] ADDR_HOUR = 19'h7FFFB;
	localparam logic [18:0] ADDR_WDAY = 19'h7FFFC;
	localparam logic [18:0] ADDR_MDAY = 19'h7FFFD;
	localparam logic [18:0] ADDR_MONTH = 19'h7FFFE;
	localparam logic [18:0] ADDR_YEAR = 19'h7FFFF;
	localparam logic [15:0] ADDR_BASE_HI = 16'hFFFF;

	localparam int CTRL_WRITE_BIT = 7;
	localparam int CTRL_READ_BIT = 6;
	localparam int CTRL_SIGN_BIT = 5;
	localparam int HALT_BIT = 7;
	localparam int FT_BIT = 6;

	localparam logic [7:0] MASK_CTRL = 8'hFF;
	localparam logic [7:0] MASK_SEC = 8'h7F;
	localparam logic [7:0] MASK_MIN = 8'h7F;
	localparam logic [7:0] MASK_HOUR = 8'h3F;
	localparam logic [7:0] MASK_WDAY = 8'h07;
	localparam logic [7:0] MASK_MDAY = 8'h3F;
	localparam logic [7:0] MASK_MONTH = 8'h1F;
	localparam logic [7:0] MASK_YEAR = 8'hFF;

	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic RST_HALT = 1'b1;
	localparam logic RST_FT = 1'b0;
	localparam logic [7:0] RST_SEC = 8'h00;
	localparam logic [7:0] RST_MIN = 8'h00;
	localparam logic [7:0] RST_HOUR = 8'h00;
	localparam logic [7:0] RST_WDAY = 8'h01;
	localparam logic [7:0] RST_MDAY = 8'h01;
	localparam logic [7:0] RST_MONTH = 8'h01;
	localparam logic [7:0] RST_YEAR = 8'h00;

	localparam logic [7:0] MAX_SEC = 8'h59;
	localparam logic [7:0] MAX_MIN = 8'h59;
	localparam logic [7:0] MAX_HOUR = 8'h23;
	localparam logic [7:0] MAX_WDAY = 8'h07;
	localparam logic [7:0] MAX_MONTH = 8'h12;
	localparam logic [7:0] MAX_YEAR = 8'h99;
	localparam logic [7:0] MIN_ZERO = 8'h00;
	localparam logic [7:0] MIN_ONE = 8'h01;

	localparam int CLK_HZ = 100000000;
	localparam int OSC_HZ = 32768;
	localparam int OSC_CYC = CLK_HZ / OSC_HZ;
	localparam logic [15:0] SEC_OSC = 16'h8000;
	localparam logic [15:0] CAL_SHORT = 16'h0080;
	localparam logic [15:0] CAL_LONG = 16'h0100;
	localparam logic [5:0] SEC_LAST = 6'h3B;
	localparam logic [5:0] CAL_CYCLE_LAST = 6'h3F;
	localparam logic [6:0] CAL_ELIG_MIN = 7'h3E;
	localparam int TEST_WAVE_BIT = 5;

	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] mday;
		logic [7:0] wday;
		logic [7:0] hours;
		logic [7:0] minutes;
		logic [7:0] seconds;
	} rtcc_time_s;

	localparam rtcc_time_s RST_TIME = '{RST_YEAR, RST_MONTH, RST_MDAY,
		RST_WDAY, RST_HOUR, RST_MIN, RST_SEC};

	// returns {carry, next}; an out-of-range value also wraps to the floor
	function automatic logic [8:0] bcd_inc(input logic [7:0] v,
		input logic [7:0] maxv, input logic [7:0] minv);
		logic [3:0] tens;
		tens = v[7:4] + 4'h1;
		if (v >= maxv)
			bcd_inc = {1'b1, minv};
		else if (v[3:0] >= 4'h9)
			bcd_inc = {1'b0, tens, 4'h0};
		else
			bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_inc

	// leap test on a bcd year: every fourth year, 00 included
	function automatic logic [7:0] month_len(input logic [7:0] month,
		input logic [7:0] year);
		logic leap;
		leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6) :
			(year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
		case (month)
			8'h02: month_len = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
			default: month_len = 8'h31;
		endcase
	endfunction : month_len

endpackage : rtcc_pkg

// ===== logic/rtcc_top.sv
// calendar clock top: byte-wide memory port, user registers, refresh control
`timescale 1ns/1ns
`default_nettype none
module rtcc_top #(
	parameter int OSC_CYC = rtcc_pkg::OSC_CYC
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [18:0] bus_addr,
	input wire logic [7:0] bus_data_in,
	input wire logic chip_en_n,
	input wire logic write_en_n,
	input wire logic out_en_n,
	output logic [7:0] bus_data_out_ff,
	output logic bus_data_oe_ff,
	output logic freq_test_out_ff
);
	logic [7:0] ctrl_ff, nxt_ctrl;
	logic oscillator_halt_bit_ff, nxt_halt;
	logic divider_test_output_bit_ff, nxt_ft;
	rtcc_pkg::rtcc_time_s usr_ff, nxt_usr;
	logic wr_act_ff;
	logic [18:0] wr_addr_ff, nxt_wr_addr;
	logic [7:0] wr_data_ff, nxt_wr_data;
	logic load_ff, nxt_load;
	logic restart_ff, nxt_restart;
	logic tick_d_ff;
	logic [7:0] nxt_dout;
	logic nxt_doe;
	logic wr_act, wr_commit, rd_act, in_map, wr_in_map;
	logic freeze;
	logic [7:0] wd;
	logic [7:0] rd_val;
	logic sec_tick, test_wave;
	rtcc_pkg::rtcc_time_s cnt;

	rtcc_divider #(
		.OSC_CYC(OSC_CYC)
	) u_div (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ce(ce),
		.hold(oscillator_halt_bit_ff),
		.restart(restart_ff),
		.cal_sign(ctrl_ff[rtcc_pkg::CTRL_SIGN_BIT]),
		.cal_mag(ctrl_ff[4:0]),
		.sec_tick_ff(sec_tick),
		.test_wave_ff(test_wave)
	);

	rtcc_calendar u_cal (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ce(ce),
		.tick(sec_tick),
		.load(load_ff),
		.load_val(usr_ff),
		.cnt_ff(cnt)
	);

	// bus decode; writes take effect on the cycle the strobe pair ends
	always_comb begin
		wr_act = !chip_en_n && !write_en_n;
		rd_act = !chip_en_n && !out_en_n && write_en_n;
		in_map = (bus_addr[18:3] == rtcc_pkg::ADDR_BASE_HI);
		wr_in_map = (wr_addr_ff[18:3] == rtcc_pkg::ADDR_BASE_HI);
		wr_commit = wr_act_ff && !wr_act && wr_in_map;
		nxt_wr_addr = wr_act ? bus_addr : wr_addr_ff;
		nxt_wr_data = wr_act ? bus_data_in : wr_data_ff;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wr_act_ff <= 1'b0;
			wr_addr_ff <= 19'h00000;
			wr_data_ff <= 8'h00;
		end else if (ce) begin
			wr_act_ff <= wr_act;
			wr_addr_ff <= nxt_wr_addr;
			wr_data_ff <= nxt_wr_data;
		end
	end

	// register file, refresh and transfer control
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_halt = oscillator_halt_bit_ff;
		nxt_ft = divider_test_output_bit_ff;
		nxt_usr = usr_ff;
		wd = wr_data_ff;
		freeze = ctrl_ff[rtcc_pkg::CTRL_WRITE_BIT] ||
			ctrl_ff[rtcc_pkg::CTRL_READ_BIT];
		// one-cycle copy of every field, so a freeze can never split it
		if (tick_d_ff && !freeze && !load_ff)
			nxt_usr = cnt;
		if (wr_commit) begin
			// fixed-zero positions are masked so they always read back zero
			case (wr_addr_ff)
				rtcc_pkg::ADDR_CTRL: nxt_ctrl = wd & rtcc_pkg::MASK_CTRL;
				rtcc_pkg::ADDR_SEC: begin
					nxt_usr.seconds = wd & rtcc_pkg::MASK_SEC;
					nxt_halt = wd[rtcc_pkg::HALT_BIT];
				end
				rtcc_pkg::ADDR_MIN: nxt_usr.minutes = wd & rtcc_pkg::MASK_MIN;
				rtcc_pkg::ADDR_HOUR: nxt_usr.hours = wd & rtcc_pkg::MASK_HOUR;
				rtcc_pkg::ADDR_WDAY: begin
					nxt_usr.wday = wd & rtcc_pkg::MASK_WDAY;
					nxt_ft = wd[rtcc_pkg::FT_BIT];
				end
				rtcc_pkg::ADDR_MDAY: nxt_usr.mday = wd & rtcc_pkg::MASK_MDAY;
				rtcc_pkg::ADDR_MONTH: nxt_usr.month = wd & rtcc_pkg::MASK_MONTH;
				rtcc_pkg::ADDR_YEAR: nxt_usr.year = wd & rtcc_pkg::MASK_YEAR;
				default: nxt_usr = nxt_usr;
			endcase
		end
		// falling write flag hands the user image to the counters
		nxt_load = ctrl_ff[rtcc_pkg::CTRL_WRITE_BIT] &&
			!nxt_ctrl[rtcc_pkg::CTRL_WRITE_BIT];
		nxt_restart = (oscillator_halt_bit_ff && !nxt_halt) || nxt_load;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_ff <= rtcc_pkg::RST_CTRL;
			oscillator_halt_bit_ff <= rtcc_pkg::RST_HALT;
			divider_test_output_bit_ff <= rtcc_pkg::RST_FT;
			usr_ff <= rtcc_pkg::RST_TIME;
			load_ff <= 1'b0;
			restart_ff <= 1'b0;
			tick_d_ff <= 1'b0;
		end else if (ce) begin
			ctrl_ff <= nxt_ctrl;
			oscillator_halt_bit_ff <= nxt_halt;
			divider_test_output_bit_ff <= nxt_ft;
			usr_ff <= nxt_usr;
			load_ff <= nxt_load;
			restart_ff <= nxt_restart;
			tick_d_ff <= sec_tick;
		end
	end

	// read path; addresses outside the clock bytes leave the bus undriven
	always_comb begin
		case (bus_addr)
			rtcc_pkg::ADDR_CTRL: rd_val = ctrl_ff;
			rtcc_pkg::ADDR_SEC: rd_val = {oscillator_halt_bit_ff,
				usr_ff.seconds[6:0]};
			rtcc_pkg::ADDR_MIN: rd_val = usr_ff.minutes;
			rtcc_pkg::ADDR_HOUR: rd_val = usr_ff.hours;
			rtcc_pkg::ADDR_WDAY: rd_val = {1'b0, divider_test_output_bit_ff,
				usr_ff.wday[5:0]};
			rtcc_pkg::ADDR_MDAY: rd_val = usr_ff.mday;
			rtcc_pkg::ADDR_MONTH: rd_val = usr_ff.month;
			rtcc_pkg::ADDR_YEAR: rd_val = usr_ff.year;
			default: rd_val = 8'h00;
		endcase
		nxt_doe = rd_act && in_map;
		nxt_dout = nxt_doe ? rd_val : 8'h00;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus_data_out_ff <= 8'h00;
			bus_data_oe_ff <= 1'b0;
			freq_test_out_ff <= 1'b0;
		end else if (ce) begin
			bus_data_out_ff <= nxt_dout;
			bus_data_oe_ff <= nxt_doe;
			freq_test_out_ff <= divider_test_output_bit_ff && test_wave;
		end
	end
endmodule : rtcc_top
`default_nettype wire

// ===== test/rtcc_host.sv
// host processor model on the byte-wide memory port
`timescale 1ns/1ns
`default_nettype none
module rtcc_host (
	input wire logic mclk,
	output var logic [18:0] bus_addr,
	output var logic [7:0] bus_data_in,
	output var logic chip_en_n,
	output var logic write_en_n,
	output var logic out_en_n,
	input wire logic [7:0] bus_data_out_ff,
	input wire logic bus_data_oe_ff
);
	initial begin
		bus_addr = 19'h00000;
		bus_data_in = 8'h00;
		chip_en_n = 1'b1;
		write_en_n = 1'b1;
		out_en_n = 1'b1;
	end
	task automatic wr(input logic [18:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_addr <= a;
		bus_data_in <= d;
		chip_en_n <= 1'b0;
		write_en_n <= 1'b0;
		@(posedge mclk);
		chip_en_n <= 1'b1;
		write_en_n <= 1'b1;
		// released data lines must not keep the last value
		bus_data_in <= ~d;
	endtask : wr
	task automatic rd(input logic [18:0] a, output logic [8:0] q);
		@(posedge mclk);
		bus_addr <= a;
		chip_en_n <= 1'b0;
		out_en_n <= 1'b0;
		@(posedge mclk);
		#1 q = {bus_data_oe_ff, bus_data_out_ff};
		@(posedge mclk);
		chip_en_n <= 1'b1;
		out_en_n <= 1'b1;
	endtask : rd
endmodule : rtcc_host
`default_nettype wire

// ===== test/rtcc_top_asserts.sv
// checker on the calendar clock top ports
`timescale 1ns/1ns
`default_nettype none
module rtcc_top_asserts #(
	parameter int OSC_CYC = rtcc_pkg::OSC_CYC
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [18:0] bus_addr,
	input wire logic [7:0] bus_data_in,
	input wire logic chip_en_n,
	input wire logic write_en_n,
	input wire logic out_en_n,
	input wire logic [7:0] bus_data_out_ff,
	input wire logic bus_data_oe_ff,
	input wire logic freq_test_out_ff
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic rd;
	logic hit;
	assign rd = ce && !chip_en_n && !out_en_n && write_en_n;
	assign hit = bus_addr[18:3] == rtcc_pkg::ADDR_BASE_HI;
	// a one-cycle write followed by the strobe rising
	sequence wr_at(logic [18:0] a);
		(ce && !chip_en_n && !write_en_n && bus_addr == a) ##1 (ce && write_en_n);
	endsequence
	sequence rd_at(logic [18:0] a);
		rd && bus_addr == a;
	endsequence
	chk_read_drive: assert property (rd && hit |=> bus_data_oe_ff)
		else $error("clock register read not driven");
	chk_stray_read: assert property (rd && !hit |-> ##1 !bus_data_oe_ff)
		else $error("read outside the clock registers driven");
	chk_month_zero: assert property (rd_at(rtcc_pkg::ADDR_MONTH) |=>
		bus_data_out_ff[7:5] == 3'h0)
		else $error("month upper bits not zero");
	chk_date_zero: assert property (rd && (bus_addr == rtcc_pkg::ADDR_MDAY ||
		bus_addr == rtcc_pkg::ADDR_HOUR) |=> bus_data_out_ff[7:6] == 2'h0)
		else $error("date or hours upper bits not zero");
	chk_wday_zero: assert property (rd_at(rtcc_pkg::ADDR_WDAY) |=>
		(bus_data_out_ff & 8'hB8) == 8'h00)
		else $error("weekday fixed bits not zero");
	chk_min_zero: assert property (rd_at(rtcc_pkg::ADDR_MIN) |=>
		!bus_data_out_ff[7])
		else $error("minutes bit 7 not zero");
	chk_ctrl_back: assert property (wr_at(rtcc_pkg::ADDR_CTRL) ##1
		rd_at(rtcc_pkg::ADDR_CTRL) |=> bus_data_out_ff == $past(bus_data_in, 3))
		else $error("control byte read back differs");
	chk_halt_back: assert property (wr_at(rtcc_pkg::ADDR_SEC) ##1
		rd_at(rtcc_pkg::ADDR_SEC) |=> bus_data_out_ff[7] == $past(bus_data_in[7], 3))
		else $error("halt bit read back differs");
endmodule : rtcc_top_asserts
bind rtcc_top rtcc_top_asserts #(.OSC_CYC(OSC_CYC)) i_rtcc_top_asserts (
	.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .bus_addr(bus_addr),
	.bus_data_in(bus_data_in), .chip_en_n(chip_en_n),
	.write_en_n(write_en_n), .out_en_n(out_en_n),
	.bus_data_out_ff(bus_data_out_ff), .bus_data_oe_ff(bus_data_oe_ff),
	.freq_test_out_ff(freq_test_out_ff));
`default_nettype wire

// ===== test/rtcc_top_bench.sv
// self-checking bench for the calendar clock top
`timescale 1ns/1ns
`default_nettype none
module rtcc_top_bench;
	// one oscillator cycle per mclk keeps a second at 32768 cycles
	localparam int OSC_CYC = 1;
	localparam int SEC_CYC = 32768 * OSC_CYC;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic [18:0] bus_addr;
	logic [7:0] bus_data_in;
	logic chip_en_n, write_en_n, out_en_n, bus_data_oe_ff, freq_test_out_ff;
	logic [7:0] bus_data_out_ff;
	int n_errors = 0;
	int tests_run = 0;
	int n;
	logic [31:0] seed = 32'h3F0F781A;
	logic [8:0] q;
	logic [7:0] v;
	// every field at its top value; fixed-zero bits written as zero
	logic [7:0] setv [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
	logic [7:0] minv [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
	initial forever #5 mclk = ~mclk;
	rtcc_top #(.OSC_CYC(OSC_CYC)) i_rtcc_top (.mclk(mclk), .sys_rst(sys_rst),
		.ce(ce), .bus_addr(bus_addr), .bus_data_in(bus_data_in),
		.chip_en_n(chip_en_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
		.bus_data_out_ff(bus_data_out_ff), .bus_data_oe_ff(bus_data_oe_ff),
		.freq_test_out_ff(freq_test_out_ff));
	rtcc_host i_rtcc_host (.mclk(mclk), .bus_addr(bus_addr),
		.bus_data_in(bus_data_in), .chip_en_n(chip_en_n),
		.write_en_n(write_en_n), .out_en_n(out_en_n),
		.bus_data_out_ff(bus_data_out_ff), .bus_data_oe_ff(bus_data_oe_ff));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] roll(input logic [7:0] x,
		input logic [7:0] mx, input logic [7:0] lo);
		roll = (x == mx) ? lo : (x[3:0] == 4'h9) ? {x[7:4] + 4'h1, 4'h0} :
			x + 8'h01;
	endfunction : roll
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic summarize;
		$display("checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	initial begin
		repeat (80000) @(posedge mclk);
		n_errors++;
		$display("unexpected at %0t: run did not finish", $time);
		summarize();
	end
	initial begin
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		i_rtcc_host.rd(rtcc_pkg::ADDR_CTRL, q);
		check(q[7:0], 8'h00);
		i_rtcc_host.rd(rtcc_pkg::ADDR_SEC, q);
		check(q[7:0], 8'h80);
		i_rtcc_host.rd(19'h7FFF7, q);
		check({7'h00, q[8]}, 8'h00);
		for (n = 0; n < 6; n++) begin
			seed = lfsr(seed);
			v = (n == 0) ? 8'h9F : (n == 1) ? 8'hBF : {2'b10, seed[5:0]};
			i_rtcc_host.wr(rtcc_pkg::ADDR_CTRL, v);
			i_rtcc_host.rd(rtcc_pkg::ADDR_CTRL, q);
			check(q[7:0], v);
		end
		for (n = 0; n < 7; n++) begin
			i_rtcc_host.wr(rtcc_pkg::ADDR_SEC + 19'(n), setv[n]);
			i_rtcc_host.rd(rtcc_pkg::ADDR_SEC + 19'(n), q);
			check(q[7:0], setv[n]);
		end
		// sign one, magnitude one: the first second after the load is short
		i_rtcc_host.wr(rtcc_pkg::ADDR_CTRL, 8'h21);
		// an uncorrected second would not have refreshed before the freeze
		repeat (SEC_CYC - 64) @(posedge mclk);
		i_rtcc_host.wr(rtcc_pkg::ADDR_CTRL, 8'h40);
		// the second pass, a second later, must still show the frozen image
		for (int p = 0; p < 2; p++) begin
			for (n = 0; n < 7; n++) begin
				i_rtcc_host.rd(rtcc_pkg::ADDR_SEC + 19'(n), q);
				check(q[7:0], roll(setv[n], setv[n], minv[n]));
			end
			if (p == 0)
				repeat (SEC_CYC) @(posedge mclk);
		end
		i_rtcc_host.wr(rtcc_pkg::ADDR_WDAY, 8'h41);
		for (int h = 0; h < 2; h++) begin
			if (h == 1)
				i_rtcc_host.wr(rtcc_pkg::ADDR_SEC, 8'h80);
			n = 0;
			for (int k = 0; k < 200; k++) begin
				@(posedge mclk);
				#1 if (freq_test_out_ff !== v[0])
					n++;
				v[0] = freq_test_out_ff;
			end
			check({7'h00, n > 3}, {7'h00, h == 0});
		end
		summarize();
	end
endmodule : rtcc_top_bench
`default_nettype wire
